// *** irq_prio_params.svh ***
`ifndef IRQ_PRIO_PARAMS_SVH
`define IRQ_PRIO_PARAMS_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define IDX_PRIO_LOW_ONE 8'h91
`define IDX_PRIO_HIGH_ONE 8'h92
`define IDX_IRQ_ENABLE_ZERO 8'hA8
`define IDX_PRIO_HIGH_ZERO 8'hB7
`define IDX_PRIO_LOW_ZERO 8'hB8
`define IDX_IRQ_ENABLE_ONE 8'hE8
`define IDX_EVT_STATUS 8'hC0
`define IDX_EVT_ENABLE 8'hC1
`define IDX_EVT_CLEAR 8'hC2
`define IDX_BIT_OP 8'hC3
`define IDX_SERVICE_STATE 8'hC4

// ************************************************************
// reset values and writable masks
// ************************************************************
`define REG_RESET 8'h00
`define MASK_FULL 8'hFF
`define MASK_EN_ONE 8'h07
`define MASK_PRIO_ONE 8'h03
`define MASK_EVT 3'h7

// ************************************************************
// fields
// ************************************************************
`define BIT_GLOBAL_EN 7
`define BITOP_TGT_HI 15
`define BITOP_TGT_LO 8
`define BITOP_VAL 3
`define BITOP_SEL_HI 2
`define EVT_GRANT 0
`define EVT_PREEMPT 1
`define EVT_RSVD_WR 2

// ************************************************************
// sources in vector order, vectors
// ************************************************************
`define SRC_EXT0 4'h0
`define SRC_TIMER0 4'h1
`define SRC_EXT1 4'h2
`define SRC_TIMER1 4'h3
`define SRC_UART 4'h4
`define SRC_I2C_ONE 4'h5
`define SRC_PCA 4'h6
`define SRC_TIMER2 4'h7
`define SRC_I2C_TWO 4'h8
`define SRC_SPI 4'h9
`define VEC_BASE 16'h0003
`define VEC_STEP 16'h0008

`endif

// *** irq_prio_pkg.sv ***
package irq_prio_pkg;
  typedef logic [1:0] level_t;
  typedef logic [3:0] src_t;
  typedef logic [7:0] sfr_t;

  // level 3 highest: high bit is the msb
  function automatic level_t level_of(input logic hi, input logic lo);
    level_of = {hi, lo};
  endfunction : level_of

  // highest level with its in-service bit set
  function automatic level_t top_level(input logic [3:0] mask);
    level_t l;
    l = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (mask[i]) begin
        l = level_t'(i);
      end
    end
    top_level = l;
  endfunction : top_level
endpackage : irq_prio_pkg

// *** irq_poll_arbiter.sv ***
`timescale 1ns/100ps
`include "irq_prio_params.svh"

module irq_poll_arbiter
  import irq_prio_pkg::*;
#(
  parameter int NUM_SRC = 10
) (
  // request state
  input wire logic [NUM_SRC-1:0] pending_i,
  input wire logic [NUM_SRC-1:0] prio_high_i,
  input wire logic [NUM_SRC-1:0] prio_low_i,
  // winner
  output logic win_valid_o,
  output src_t win_src_o,
  output level_t win_level_o
);
  // ************************************************************
  // fixed polling order among equal levels
  // ************************************************************
  localparam src_t POLL [10] = '{`SRC_EXT0, `SRC_I2C_ONE, `SRC_TIMER0, `SRC_EXT1,
    `SRC_TIMER1, `SRC_UART, `SRC_TIMER2, `SRC_PCA, `SRC_SPI, `SRC_I2C_TWO};

  if (NUM_SRC != 10) begin : g_num_src_chk
    $error("irq_poll_arbiter serves exactly ten sources");
  end

  always_comb begin
    src_t s;
    level_t l;
    s = 4'h0;
    l = 2'h0;
    win_valid_o = 1'b0;
    win_src_o = 4'h0;
    win_level_o = 2'h0;
    // strict greater keeps the earliest polled source on a tie
    for (int p = 0; p < 10; p++) begin
      s = POLL[p];
      l = level_of(prio_high_i[s], prio_low_i[s]);
      if (pending_i[s] && (!win_valid_o || l > win_level_o)) begin
        win_valid_o = 1'b1;
        win_src_o = s;
        win_level_o = l;
      end
    end
  end
endmodule : irq_poll_arbiter

// *** irq_enable_priority_regs.sv ***
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`include "irq_prio_params.svh"
// Notes on behaviour
// - enable zero: global and seven source enables
// - enable one: spi, i2c two, timer2 enables
// - low priority zero: eight source low bits
// - high priority zero: matching high bits
// - low priority one: spi, i2c two
// - high priority one: spi, i2c two
// - all six registers reset to zero
// - bit ops on enables, low priorities only
// - four levels from high/low bit pair
// - fixed vectors, fixed polling order on ties

module irq_enable_priority_regs
  import irq_prio_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // interrupt sources, same clock
  input wire logic [9:0] irq_flags_i,
  // core sequencer
  input wire logic irq_ack_i,
  input wire logic irq_reti_i,
  output logic irq_req_o,
  output logic [15:0] irq_vector_o,
  output src_t irq_src_o,
  output level_t irq_level_o,
  // event interrupt
  output logic evt_irq_o
);
  if (ADDR_W < 10) begin : g_addr_w_chk
    $error("ADDR_W must hold the register index");
  end

  // ************************************************************
  // state
  // ************************************************************
  sfr_t en0_r, en0_nxt, en1_r, en1_nxt;
  sfr_t plo0_r, plo0_nxt, plo1_r, plo1_nxt;
  sfr_t phi0_r, phi0_nxt, phi1_r, phi1_nxt;
  logic [2:0] evt_stat_r, evt_stat_nxt, evt_en_r, evt_en_nxt;
  logic evt_irq_r, evt_irq_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [3:0] in_svc_r, in_svc_nxt;
  logic req_r, req_nxt;
  logic [15:0] vec_r, vec_nxt;
  src_t src_r, src_nxt;
  level_t lvl_r, lvl_nxt;

  // ************************************************************
  // decode
  // ************************************************************
  logic [7:0] idx;
  logic in_range, setup, wr_done, rd_setup, mapped, wr_rsvd, bitop_bad;
  logic [7:0] bit_tgt;
  logic [2:0] bit_sel;
  logic bit_val, bitop_wr;
  assign idx = paddr_i[9:2];
  assign in_range = (paddr_i >> 10) == '0;
  assign setup = psel_i && !penable_i;
  assign wr_done = psel_i && penable_i && pready_r && pwrite_i && !pslverr_r;
  assign rd_setup = setup && !pwrite_i;
  assign bit_tgt = pwdata_i[`BITOP_TGT_HI:`BITOP_TGT_LO];
  assign bit_sel = pwdata_i[`BITOP_SEL_HI:0];
  assign bit_val = pwdata_i[`BITOP_VAL];
  assign bitop_wr = wr_done && idx == `IDX_BIT_OP;

  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = i == `IDX_PRIO_LOW_ONE || i == `IDX_PRIO_HIGH_ONE ||
      i == `IDX_IRQ_ENABLE_ZERO || i == `IDX_PRIO_HIGH_ZERO ||
      i == `IDX_PRIO_LOW_ZERO || i == `IDX_IRQ_ENABLE_ONE ||
      i == `IDX_EVT_STATUS || i == `IDX_EVT_ENABLE || i == `IDX_EVT_CLEAR ||
      i == `IDX_BIT_OP || i == `IDX_SERVICE_STATE;
  endfunction : is_mapped

  // only the four bit-addressable registers take single-bit ops
  function automatic logic bit_addressable(input logic [7:0] i);
    bit_addressable = i == `IDX_IRQ_ENABLE_ZERO || i == `IDX_IRQ_ENABLE_ONE ||
      i == `IDX_PRIO_LOW_ZERO || i == `IDX_PRIO_LOW_ONE;
  endfunction : bit_addressable

  // one bit replaced, others kept, then masked
  function automatic sfr_t set_bit(input sfr_t v, input logic [2:0] b, input logic x,
                                   input sfr_t m);
    sfr_t t;
    t = v;
    t[b] = x;
    set_bit = t & m;
  endfunction : set_bit

  assign mapped = in_range && is_mapped(idx);
  assign bitop_bad = pwrite_i && idx == `IDX_BIT_OP && !bit_addressable(bit_tgt);

  // reserved bits written as one by software are dropped and flagged
  always_comb begin
    wr_rsvd = 1'b0;
    if (wr_done) begin
      case (idx)
        `IDX_IRQ_ENABLE_ONE: wr_rsvd = |(pwdata_i[7:0] & ~`MASK_EN_ONE);
        `IDX_PRIO_LOW_ONE,
        `IDX_PRIO_HIGH_ONE: wr_rsvd = |(pwdata_i[7:0] & ~`MASK_PRIO_ONE);
        `IDX_BIT_OP: wr_rsvd = (bit_tgt == `IDX_IRQ_ENABLE_ONE && bit_sel > 3'h2 && bit_val) ||
          (bit_tgt == `IDX_PRIO_LOW_ONE && bit_sel > 3'h1 && bit_val);
        default: wr_rsvd = 1'b0;
      endcase
    end
  end

  // ************************************************************
  // enable and priority registers
  // ************************************************************
  always_comb begin
    en0_nxt = en0_r;
    en1_nxt = en1_r;
    plo0_nxt = plo0_r;
    plo1_nxt = plo1_r;
    phi0_nxt = phi0_r;
    phi1_nxt = phi1_r;
    if (wr_done) begin
      case (idx)
        `IDX_IRQ_ENABLE_ZERO: en0_nxt = pwdata_i[7:0];
        `IDX_IRQ_ENABLE_ONE: en1_nxt = pwdata_i[7:0] & `MASK_EN_ONE;
        `IDX_PRIO_LOW_ZERO: plo0_nxt = pwdata_i[7:0];
        `IDX_PRIO_HIGH_ZERO: phi0_nxt = pwdata_i[7:0];
        `IDX_PRIO_LOW_ONE: plo1_nxt = pwdata_i[7:0] & `MASK_PRIO_ONE;
        `IDX_PRIO_HIGH_ONE: phi1_nxt = pwdata_i[7:0] & `MASK_PRIO_ONE;
        `IDX_BIT_OP: begin
          case (bit_tgt)
            `IDX_IRQ_ENABLE_ZERO: en0_nxt = set_bit(en0_r, bit_sel, bit_val, `MASK_FULL);
            `IDX_IRQ_ENABLE_ONE: en1_nxt = set_bit(en1_r, bit_sel, bit_val, `MASK_EN_ONE);
            `IDX_PRIO_LOW_ZERO: plo0_nxt = set_bit(plo0_r, bit_sel, bit_val, `MASK_FULL);
            `IDX_PRIO_LOW_ONE: plo1_nxt = set_bit(plo1_r, bit_sel, bit_val, `MASK_PRIO_ONE);
            default: en0_nxt = en0_r;
          endcase
        end
        default: en0_nxt = en0_r;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      en0_r <= `REG_RESET;
      en1_r <= `REG_RESET;
      plo0_r <= `REG_RESET;
      plo1_r <= `REG_RESET;
      phi0_r <= `REG_RESET;
      phi1_r <= `REG_RESET;
    end else begin
      en0_r <= en0_nxt;
      en1_r <= en1_nxt;
      plo0_r <= plo0_nxt;
      plo1_r <= plo1_nxt;
      phi0_r <= phi0_nxt;
      phi1_r <= phi1_nxt;
    end
  end

  // ************************************************************
  // arbitration and service nesting
  // ************************************************************
  logic [9:0] src_en, src_hi, src_lo;
  logic win_valid, active, eligible;
  src_t win_src;
  level_t win_level, cur_level;
  assign src_en = {en1_r[2:0], en0_r[6:0]};
  assign src_hi = {phi1_r[1:0], phi0_r};
  assign src_lo = {plo1_r[1:0], plo0_r};
  assign active = |in_svc_r;
  assign cur_level = top_level(in_svc_r);
  assign eligible = !active || win_level > cur_level;

  irq_poll_arbiter #(
    .NUM_SRC(10)
  ) u_arb (
    .pending_i(irq_flags_i & src_en),
    .prio_high_i(src_hi),
    .prio_low_i(src_lo),
    .win_valid_o(win_valid),
    .win_src_o(win_src),
    .win_level_o(win_level)
  );

  logic take;
  assign take = irq_ack_i && req_r;

  always_comb begin
    in_svc_nxt = in_svc_r;
    if (irq_reti_i && active) begin
      in_svc_nxt[cur_level] = 1'b0;
    end
    if (take) begin
      in_svc_nxt[lvl_r] = 1'b1;
    end
    // dropped in the ack cycle so one grant gives one entry
    req_nxt = en0_r[`BIT_GLOBAL_EN] && win_valid && eligible && !take;
    src_nxt = win_src;
    lvl_nxt = win_level;
    vec_nxt = `VEC_BASE + 16'(win_src) * `VEC_STEP;
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      in_svc_r <= 4'h0;
      req_r <= 1'b0;
      src_r <= 4'h0;
      lvl_r <= 2'h0;
      vec_r <= `VEC_BASE;
    end else begin
      in_svc_r <= in_svc_nxt;
      req_r <= req_nxt;
      src_r <= src_nxt;
      lvl_r <= lvl_nxt;
      vec_r <= vec_nxt;
    end
  end

  // ************************************************************
  // events and bus answer
  // ************************************************************
  logic [2:0] evt_set;
  assign evt_set = {wr_rsvd, take && active, take};

  always_comb begin
    evt_en_nxt = evt_en_r;
    evt_stat_nxt = evt_stat_r;
    if (wr_done && idx == `IDX_EVT_ENABLE) begin
      evt_en_nxt = pwdata_i[2:0] & `MASK_EVT;
    end
    if (wr_done && idx == `IDX_EVT_CLEAR) begin
      evt_stat_nxt = evt_stat_r & ~pwdata_i[2:0];
    end
    // a set in the clear cycle wins
    evt_stat_nxt = evt_stat_nxt | evt_set;
    evt_irq_nxt = |(evt_stat_nxt & evt_en_nxt);
    pready_nxt = setup;
    pslverr_nxt = setup && (!mapped || bitop_bad);
    prdata_nxt = 32'h0000_0000;
    if (rd_setup && mapped) begin
      case (idx)
        `IDX_IRQ_ENABLE_ZERO: prdata_nxt = {24'h00_0000, en0_r};
        `IDX_IRQ_ENABLE_ONE: prdata_nxt = {24'h00_0000, en1_r & `MASK_EN_ONE};
        `IDX_PRIO_LOW_ZERO: prdata_nxt = {24'h00_0000, plo0_r};
        `IDX_PRIO_HIGH_ZERO: prdata_nxt = {24'h00_0000, phi0_r};
        `IDX_PRIO_LOW_ONE: prdata_nxt = {24'h00_0000, plo1_r & `MASK_PRIO_ONE};
        `IDX_PRIO_HIGH_ONE: prdata_nxt = {24'h00_0000, phi1_r & `MASK_PRIO_ONE};
        `IDX_EVT_STATUS: prdata_nxt = {29'h0000_0000, evt_stat_r};
        `IDX_EVT_ENABLE: prdata_nxt = {29'h0000_0000, evt_en_r};
        `IDX_SERVICE_STATE: prdata_nxt = {24'h00_0000, req_r, 1'b0, cur_level, in_svc_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      evt_en_r <= 3'h0;
      evt_stat_r <= 3'h0;
      evt_irq_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      evt_en_r <= evt_en_nxt;
      evt_stat_r <= evt_stat_nxt;
      evt_irq_r <= evt_irq_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign irq_req_o = req_r;
  assign irq_vector_o = vec_r;
  assign irq_src_o = src_r;
  assign irq_level_o = lvl_r;
  assign evt_irq_o = evt_irq_r;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_global_off;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      !en0_r[`BIT_GLOBAL_EN] |=> !irq_req_o;
  endproperty
  a_global_off: assert property (p_global_off) else $error("request with global enable off");
  property p_en0_write;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      wr_done && idx == `IDX_IRQ_ENABLE_ZERO |=> en0_r == $past(pwdata_i[7:0]);
  endproperty
  a_en0_write: assert property (p_en0_write) else $error("enable zero write lost");
  property p_en1_rsvd;
    @(posedge core_clk_i) disable iff (!reset_n_i) en1_r[7:3] == 5'h00;
  endproperty
  a_en1_rsvd: assert property (p_en1_rsvd) else $error("enable one reserved bit set");
  property p_prio_one_rsvd;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      plo1_r[7:2] == 6'h00 && phi1_r[7:2] == 6'h00;
  endproperty
  a_prio_one_rsvd: assert property (p_prio_one_rsvd) else $error("prio one reserved set");
  property p_phi0_write;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      wr_done && idx == `IDX_PRIO_HIGH_ZERO |=> phi0_r == $past(pwdata_i[7:0])
      ##1 phi0_r == $past(phi0_r);
  endproperty
  a_phi0_write: assert property (p_phi0_write) else $error("high priority zero write");
  property p_reset_zero;
    @(posedge core_clk_i) !reset_n_i |=> en0_r == 8'h00 && en1_r == 8'h00 && plo0_r == 8'h00 &&
      plo1_r == 8'h00 && phi0_r == 8'h00 && phi1_r == 8'h00 && !irq_req_o;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("register not cleared by reset");
  property p_bitop_high_refused;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      setup && pwrite_i && idx == `IDX_BIT_OP && in_range && bit_tgt == `IDX_PRIO_HIGH_ZERO
      |=> pslverr_o && pready_o ##1 $stable(phi0_r);
  endproperty
  a_bitop_high_refused: assert property (p_bitop_high_refused) else $error("bit op taken");
  property p_vector;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      irq_req_o |-> irq_vector_o == `VEC_BASE + 16'(irq_src_o) * `VEC_STEP && irq_src_o <= 4'h9;
  endproperty
  a_vector: assert property (p_vector) else $error("vector does not match source");
  property p_preempt;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      $past(active) && irq_req_o && $past(reset_n_i) |-> irq_level_o > $past(cur_level);
  endproperty
  a_preempt: assert property (p_preempt) else $error("request without higher level");
  property p_level_pair;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      win_valid |=> lvl_r == level_of($past(src_hi[win_src]), $past(src_lo[win_src]));
  endproperty
  a_level_pair: assert property (p_level_pair) else $error("level not from bit pair");
  property p_evt_irq;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      |(evt_stat_r & evt_en_r) |-> evt_irq_o;
  endproperty
  a_evt_irq: assert property (p_evt_irq) else $error("event interrupt missing");
  property p_evt_grant;
    @(posedge core_clk_i) disable iff (!reset_n_i) take |=> evt_stat_r[`EVT_GRANT];
  endproperty
  a_evt_grant: assert property (p_evt_grant) else $error("grant not recorded");

  c_grant: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) take);
  c_nested: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) take && active);
  c_bitop: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) bitop_wr);
  c_rsvd: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) wr_rsvd);
endmodule : irq_enable_priority_regs

// *** core_seq_model.sv ***
`timescale 1ns/100ps
// ************************************
// core sequencer model
// ************************************
module core_seq_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // control from the bench
  input wire logic take_i,
  input wire logic ret_i,
  input wire logic [3:0] dly_i,
  // block side
  input wire logic irq_req_i,
  output logic ack_o,
  output logic reti_o
);
  logic [3:0] cnt_r;
  // acks only an offered request, after dly_i cycles, never two in a row
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_r <= 4'h0;
      ack_o <= 1'b0;
      reti_o <= 1'b0;
    end else begin
      reti_o <= ret_i;
      if (ack_o) begin
        ack_o <= 1'b0;
        cnt_r <= 4'h0;
      end else if (take_i && irq_req_i) begin
        if (cnt_r >= dly_i) begin
          ack_o <= 1'b1;
          cnt_r <= 4'h0;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end else begin
        cnt_r <= 4'h0;
      end
    end
  end
endmodule : core_seq_model

// *** test_irq_enable_priority_regs.sv ***
`timescale 1ns/100ps
`include "irq_prio_params.svh"
module test_irq_enable_priority_regs
  import irq_prio_pkg::*;
;
  // ************************************
  // stimulus and design
  // ************************************
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [9:0] flags = 10'h000;
  logic take = 1'b0;
  logic ret = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [15:0] vec;
  logic pready, pslverr, err, ack, reti, req, evt_irq;
  src_t src;
  level_t lvl;
  int n_mismatch = 0;
  int cmp_count = 0;
  localparam logic [7:0] EN0 = `IDX_IRQ_ENABLE_ZERO;
  localparam logic [7:0] EN1 = `IDX_IRQ_ENABLE_ONE;
  localparam logic [7:0] PL0 = `IDX_PRIO_LOW_ZERO;
  localparam logic [7:0] PH0 = `IDX_PRIO_HIGH_ZERO;
  localparam logic [7:0] PL1 = `IDX_PRIO_LOW_ONE;
  localparam logic [7:0] PH1 = `IDX_PRIO_HIGH_ONE;
  logic [7:0] regs [6] = '{EN0, EN1, PL0, PH0, PL1, PH1};
  logic [15:0] msk [6] = '{16'h00FF, 16'h0007, 16'h00FF, 16'h00FF, 16'h0003, 16'h0003};
  logic [7:0] tgt [6] = '{EN0, EN1, PL0, PL1, PH0, PH1};
  // set bit 1, set bit 0, clear bit 1, clear bit 0
  logic [15:0] bexp [4] = '{16'h0002, 16'h0003, 16'h0001, 16'h0000};
  // service order among equal levels
  src_t ord [10] = '{4'h0, 4'h5, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h6, 4'h9, 4'h8};

  always #25 core_clk = ~core_clk;

  irq_enable_priority_regs #(.ADDR_W(12)) dut (
    .core_clk_i(core_clk), .reset_n_i(reset_n),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .irq_flags_i(flags), .irq_ack_i(ack), .irq_reti_i(reti), .irq_req_o(req),
    .irq_vector_o(vec), .irq_src_o(src), .irq_level_o(lvl), .evt_irq_o(evt_irq)
  );

  core_seq_model seq (
    .clk_i(core_clk), .reset_n_i(reset_n), .take_i(take), .ret_i(ret),
    .dly_i(dly), .irq_req_i(req), .ack_o(ack), .reti_o(reti)
  );

  // ************************************
  // tasks
  // ************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; entered and left just after a rising edge
  task apb(input logic wr_en, input logic [7:0] idx, input logic [15:0] d);
    int g;
    g = 0;
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      g++;
    end while (pready !== 1'b1 && g < 16);
    chk(32'(g < 16), 32'h0000_0001);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task wr(input logic [7:0] idx, input logic [15:0] d, input logic e);
    apb(1'b1, idx, d);
    chk(32'(err), 32'(e));
  endtask : wr

  task rdc(input logic [7:0] idx, input logic [15:0] exp, input logic e);
    apb(1'b0, idx, 16'h0000);
    chk(rd, {16'h0000, exp});
    chk(32'(err), 32'(e));
  endtask : rdc

  task ochk(input logic r, input src_t s, input level_t l);
    repeat (3) @(posedge core_clk);
    chk(32'(req), 32'(r));
    if (r) begin
      chk(32'(src), 32'(s));
      chk(32'(lvl), 32'(l));
      chk(32'(vec), 32'h0000_0003 + 32'h0000_0008 * 32'(s));
    end
  endtask : ochk

  task wack;
    int g;
    g = 0;
    take <= 1'b1;
    do begin
      @(posedge core_clk);
      g++;
    end while (ack !== 1'b1 && g < 40);
    chk(32'(ack), 32'h0000_0001);
    take <= 1'b0;
  endtask : wack

  task pop;
    ret <= 1'b1;
    @(posedge core_clk);
    ret <= 1'b0;
    @(posedge core_clk);
  endtask : pop

  task wrap_up;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // ************************************
  // tests
  // ************************************
  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 6; i++) rdc(regs[i], 16'h0000, 1'b0);
    for (int i = 0; i < 6; i++) begin
      wr(regs[i], 16'h00FF, 1'b0);
      rdc(regs[i], msk[i], 1'b0);
      wr(regs[i], 16'h0000, 1'b0);
    end
    rdc(`IDX_EVT_STATUS, 16'h0004, 1'b0);
    wr(`IDX_EVT_ENABLE, 16'h0004, 1'b0);
    chk(32'(evt_irq), 32'h0000_0001);
    wr(`IDX_EVT_ENABLE, 16'h0000, 1'b0);
    chk(32'(evt_irq), 32'h0000_0000);
    wr(`IDX_EVT_CLEAR, 16'h0004, 1'b0);
    rdc(`IDX_EVT_STATUS, 16'h0000, 1'b0);
    wr(`IDX_EVT_ENABLE, 16'h0007, 1'b0);
    wr(8'h10, 16'h00FF, 1'b1);
    rdc(8'h10, 16'h0000, 1'b1);
    // bit ops: only enables and low priorities take them, other bits kept
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 4; k++) begin
        wr(`IDX_BIT_OP, {tgt[i], 4'h0, 1'(k < 2), 3'(1 - k % 2)}, i > 3);
        rdc(tgt[i], (i < 4) ? bexp[k] : 16'h0000, 1'b0);
      end
    end
    // a reserved bit set through a bit op is dropped and flagged
    wr(`IDX_BIT_OP, {EN1, 8'h0D}, 1'b0);
    rdc(EN1, 16'h0000, 1'b0);
    rdc(`IDX_EVT_STATUS, 16'h0004, 1'b0);
    chk(32'(evt_irq), 32'h0000_0001);
    wr(`IDX_EVT_CLEAR, 16'h0004, 1'b0);
    chk(32'(evt_irq), 32'h0000_0000);
    flags <= 10'h001;
    wr(EN0, 16'h0001, 1'b0);
    ochk(1'b0, 4'h0, 2'h0);
    wr(EN0, 16'h0081, 1'b0);
    ochk(1'b1, 4'h0, 2'h0);
    flags <= 10'h3FF;
    wr(EN1, 16'h0007, 1'b0);
    wr(EN0, 16'h007F, 1'b0);
    ochk(1'b0, 4'h0, 2'h0);
    wr(EN0, 16'h00FF, 1'b0);
    for (int i = 0; i < 10; i++) begin
      ochk(1'b1, ord[i], 2'h0);
      flags[ord[i]] <= 1'b0;
    end
    ochk(1'b0, 4'h0, 2'h0);
    // ext0 at level 1 against one source at level 2 or 3
    for (int s = 1; s < 10; s++) begin
      flags <= 10'h001 | (10'h001 << s);
      if (s < 8) begin
        wr(PL0, 16'h0001 | (16'(s % 2) << s), 1'b0);
        wr(PH0, 16'h0001 << s, 1'b0);
      end else begin
        wr(PL0, 16'h0001, 1'b0);
        wr(PL1, 16'(s % 2) << (s - 8), 1'b0);
        wr(PH1, 16'h0001 << (s - 8), 1'b0);
      end
      ochk(1'b1, src_t'(s), level_t'(2 + s % 2));
      wr(PH0, 16'h0000, 1'b0);
      wr(PL1, 16'h0000, 1'b0);
      wr(PH1, 16'h0000, 1'b0);
    end
    // service at level 1, then equal and higher requests
    flags <= 10'h001;
    wr(PL0, 16'h0003, 1'b0);
    dly <= 4'h3;
    wack;
    flags <= 10'h002;
    ochk(1'b0, 4'h0, 2'h0);
    wr(PH0, 16'h0002, 1'b0);
    ochk(1'b1, 4'h1, 2'h3);
    dly <= 4'h0;
    wack;
    flags <= 10'h000;
    rdc(`IDX_SERVICE_STATE, 16'h003A, 1'b0);
    rdc(`IDX_EVT_STATUS, 16'h0003, 1'b0);
    chk(32'(evt_irq), 32'h0000_0001);
    wr(`IDX_EVT_CLEAR, 16'h0007, 1'b0);
    rdc(`IDX_EVT_STATUS, 16'h0000, 1'b0);
    chk(32'(evt_irq), 32'h0000_0000);
    pop;
    rdc(`IDX_SERVICE_STATE, 16'h0012, 1'b0);
    pop;
    rdc(`IDX_SERVICE_STATE, 16'h0000, 1'b0);
    wrap_up;
  end

  // a hung handshake ends the run here
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    wrap_up;
  end
endmodule : test_irq_enable_priority_regs
